// ---- hw/dds_pins_pkg.sv ----
// How it works
// - sync clock is system clock over four, disableable
// - update rising edge copies buffer to active
// - host holds update high two sync periods
// - update and profile change at sync rising edge
// - profile function field only reported, profile pins pass straight through
// - serial port answers only while select low
// - write on clock rise, read on fall
// - first data line serves serial port only
// - line two may trigger ramps
// - mode select high enables crystal oscillator
// - global reset forces registers to defaults
package dds_pins_pkg;
  localparam int unsigned          sync_div          = 4;
  localparam int unsigned          sclk_half         = 8;
  localparam logic [7:0]           read_flag         = 8'h80;
  localparam int unsigned          ppc_lsb           = 12;
  localparam int unsigned          ppc_msb           = 14;
  localparam logic [23:0]          func_one_reset    = 24'h000000;
  localparam logic [7:0]           func_one_addr     = 8'h01;
  localparam logic [2:0]           ramp_pins_sdio    = 3'h1;
endpackage

// ---- hw/dds_pins_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface dds_pins_if;
  logic       sync_clk;
  logic       io_update;
  logic [3:0] profile_select_pins;
  logic       cs_n;
  logic       sclk;
  logic [3:0] sdio_host;
  logic [3:0] sdio_host_oe;
  logic [3:0] sdio_dev;
  logic [3:0] sdio_dev_oe;
  logic       osc_mode_sel;
  logic       master_reset;
  logic [3:0] sdio;
  // wire level from the two enables
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sdio[i] = sdio_dev_oe[i] ? sdio_dev[i] : (sdio_host_oe[i] ? sdio_host[i] : 1'b0);
    end
  end
  modport device (output sync_clk, sdio_dev, sdio_dev_oe,
                  input io_update, profile_select_pins, cs_n, sclk, sdio, osc_mode_sel, master_reset);
  modport host (input sync_clk, sdio,
                output io_update, profile_select_pins, cs_n, sclk, sdio_host, sdio_host_oe,
                osc_mode_sel, master_reset);
endinterface
`default_nettype wire

// ---- hw/dds_pins_device.sv ----
`timescale 1ns/10ps
`default_nettype none
module dds_pins_device (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // pins
  dds_pins_if.device       pins,
  // user side
  input  wire logic        sync_en_i,
  output logic [23:0]      func_one_o,
  output logic [7:0]       active_addr_o,
  output logic [23:0]      active_data_o,
  output logic             update_pulse_o,
  output logic [3:0]       profile_o,
  output logic [2:0]       profile_function_o,
  output logic             ramp_up_o,
  output logic             ramp_down_o,
  output logic             osc_enable_o
);
  logic [1:0]  div, next_div;
  logic        sclk_o, next_sclk_o;
  logic [1:0]  s_cs, s_sck, s_upd, s_d0, s_d1;
  logic [1:0]  s_p0, s_p1, s_p2, s_p3, s_rst, s_osc;
  logic        sck_q, upd_q, next_sck_q, next_upd_q;
  logic [5:0]  bitcnt, next_bitcnt;
  logic [31:0] shreg, next_shreg;
  logic [7:0]  b_addr, next_b_addr;
  logic [23:0] b_data, next_b_data;
  logic        b_valid, next_b_valid;
  logic        rd, next_rd;
  logic        dout, next_dout;
  logic        doe, next_doe;
  logic [23:0] f1, next_f1;
  logic [7:0]  a_addr, next_a_addr;
  logic [23:0] a_data, next_a_data;
  logic        upd_p, next_upd_p;
  logic [3:0]  prof, next_prof;
  logic        ru, rdn, next_ru, next_rdn, osc, next_osc;
  logic        sck_rise, sck_fall, upd_rise, rst;
  // synchronisers for every input pin but data lines three and four
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {s_cs, s_sck, s_upd, s_d0, s_d1} <= {2'h3, 8'h00};
      {s_p0, s_p1, s_p2, s_p3, s_rst, s_osc} <= 12'h000;
    end else begin
      s_cs  <= {s_cs[0], pins.cs_n};
      s_sck <= {s_sck[0], pins.sclk};
      s_upd <= {s_upd[0], pins.io_update};
      s_d0  <= {s_d0[0], pins.sdio[0]};
      s_d1  <= {s_d1[0], pins.sdio[1]};
      s_p0  <= {s_p0[0], pins.profile_select_pins[0]};
      s_p1  <= {s_p1[0], pins.profile_select_pins[1]};
      s_p2  <= {s_p2[0], pins.profile_select_pins[2]};
      s_p3  <= {s_p3[0], pins.profile_select_pins[3]};
      s_rst <= {s_rst[0], pins.master_reset};
      s_osc <= {s_osc[0], pins.osc_mode_sel};
    end
  end
  assign rst      = s_rst[1];
  assign sck_rise = s_sck[1] & ~sck_q;
  assign sck_fall = ~s_sck[1] & sck_q;
  assign upd_rise = s_upd[1] & ~upd_q;
  // next state of serial port, sync clock and active registers
  always_comb begin
    next_div     = div + 2'h1;
    next_sclk_o  = sync_en_i & (div < 2'h2);
    next_sck_q   = s_sck[1];
    next_upd_q   = s_upd[1];
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_b_addr  = b_addr;
    next_b_data  = b_data;
    next_b_valid = b_valid;
    next_rd      = rd;
    next_dout    = dout;
    next_doe     = doe;
    next_f1      = f1;
    next_a_addr  = a_addr;
    next_a_data  = a_data;
    next_upd_p   = 1'b0;
    next_prof    = {s_p3[1], s_p2[1], s_p1[1], s_p0[1]};
    next_osc     = s_osc[1];
    next_ru      = 1'b0;
    next_rdn     = 1'b0;
    if (s_cs[1]) begin
      next_bitcnt = 6'h00;
      next_doe    = 1'b0;
    end else begin
      if (sck_rise) begin
        next_shreg  = {shreg[30:0], s_d0[1]};
        next_bitcnt = bitcnt + 6'h01;
        if (bitcnt == 6'h07) begin
          next_rd     = shreg[6];
          next_b_addr = {shreg[6:0], s_d0[1]};
        end
        if (bitcnt == 6'h1f && !rd) begin
          next_b_data  = {shreg[22:0], s_d0[1]};
          next_b_valid = 1'b1;
        end
      end
      if (sck_fall && rd && bitcnt >= 6'h08 && bitcnt < 6'h20) begin
        next_doe  = 1'b1;
        next_dout = f1[5'd31 - bitcnt[4:0]];
      end
    end
    if (upd_rise) begin
      next_upd_p   = 1'b1;
      next_a_addr  = b_addr;
      next_a_data  = b_data;
      next_b_valid = 1'b0;
      if (b_valid && b_addr == dds_pins_pkg::func_one_addr) next_f1 = b_data;
    end
    if (f1[2:0] == dds_pins_pkg::ramp_pins_sdio && s_cs[1]) begin
      next_ru  = s_d1[1];
      next_rdn = ~s_d1[1];
    end
    if (rst) begin
      next_f1      = dds_pins_pkg::func_one_reset;
      next_b_valid = 1'b0;
      next_a_addr  = 8'h00;
      next_a_data  = 24'h000000;
      next_bitcnt  = 6'h00;
      next_doe     = 1'b0;
    end
  end
  // registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div <= 2'h0; sclk_o <= 1'b0; sck_q <= 1'b0; upd_q <= 1'b0;
      bitcnt <= 6'h00; shreg <= 32'h0; b_addr <= 8'h00; b_data <= 24'h0;
      b_valid <= 1'b0; rd <= 1'b0; dout <= 1'b0; doe <= 1'b0;
      f1 <= dds_pins_pkg::func_one_reset; a_addr <= 8'h00; a_data <= 24'h0;
      upd_p <= 1'b0; prof <= 4'h0; ru <= 1'b0; rdn <= 1'b0; osc <= 1'b0;
    end else begin
      div <= next_div; sclk_o <= next_sclk_o; sck_q <= next_sck_q; upd_q <= next_upd_q;
      bitcnt <= next_bitcnt; shreg <= next_shreg; b_addr <= next_b_addr; b_data <= next_b_data;
      b_valid <= next_b_valid; rd <= next_rd; dout <= next_dout; doe <= next_doe;
      f1 <= next_f1; a_addr <= next_a_addr; a_data <= next_a_data;
      upd_p <= next_upd_p; prof <= next_prof; ru <= next_ru; rdn <= next_rdn; osc <= next_osc;
    end
  end
  // outputs straight from flops
  assign pins.sync_clk    = sclk_o;
  assign pins.sdio_dev    = {3'h0, dout};
  assign pins.sdio_dev_oe = {3'h0, doe};
  assign func_one_o         = f1;
  assign active_addr_o      = a_addr;
  assign active_data_o      = a_data;
  assign update_pulse_o     = upd_p;
  assign profile_o          = prof;
  assign profile_function_o = f1[dds_pins_pkg::ppc_msb:dds_pins_pkg::ppc_lsb];
  assign ramp_up_o          = ru;
  assign ramp_down_o        = rdn;
  assign osc_enable_o       = osc;
endmodule
`default_nettype wire

// ---- hw/dds_pins_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module dds_pins_host (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // pins
  dds_pins_if.host         pins,
  // user side
  input  wire logic        start_i,
  input  wire logic        read_i,
  input  wire logic [6:0]  addr_i,
  input  wire logic [23:0] data_i,
  input  wire logic        update_i,
  input  wire logic [3:0]  profile_i,
  input  wire logic        osc_sel_i,
  input  wire logic        master_reset_i,
  output logic             busy_o,
  output logic [23:0]      rdata_o
);
  typedef enum logic [2:0] {idle_s = 3'b001, shift_s = 3'b010, done_s = 3'b100} state_t;
  state_t      state, next_state;
  logic [1:0]  s_sync, s_sd;
  logic        sync_q, next_sync_q;
  logic [3:0]  hc, next_hc;
  logic [5:0]  bc, next_bc;
  logic [31:0] sh, next_sh;
  logic [23:0] rd, next_rd;
  logic        rdf, next_rdf;
  logic        sck, next_sck, cs_n, next_cs_n;
  logic        upd_req, next_upd_req, upd, next_upd;
  logic [1:0]  upd_cnt, next_upd_cnt;
  logic [3:0]  prof, next_prof;
  logic        sync_rise;
  logic        busy, next_busy, oe, next_oe;
  // pin synchronisers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_sync <= 2'h0;
      s_sd   <= 2'h0;
    end else begin
      s_sync <= {s_sync[0], pins.sync_clk};
      s_sd   <= {s_sd[0], pins.sdio[0]};
    end
  end
  assign sync_rise = s_sync[1] & ~sync_q;
  // next state
  always_comb begin
    next_state   = state;
    next_sync_q  = s_sync[1];
    next_hc      = hc;
    next_bc      = bc;
    next_sh      = sh;
    next_rd      = rd;
    next_rdf     = rdf;
    next_sck     = sck;
    next_cs_n    = cs_n;
    next_upd_req = upd_req | update_i;
    next_upd     = upd;
    next_upd_cnt = upd_cnt;
    next_prof    = prof;
    case (state)
      idle_s: begin
        if (start_i) begin
          next_state = shift_s;
          next_cs_n  = 1'b0;
          next_sh    = {read_i, addr_i, data_i};
          next_rdf   = read_i;
          next_bc    = 6'h00;
          next_hc    = 4'h0;
        end
      end
      shift_s: begin
        next_hc = hc + 4'h1;
        if (hc == 4'(dds_pins_pkg::sclk_half - 1)) begin
          next_hc  = 4'h0;
          next_sck = ~sck;
          if (!sck) begin
            next_bc = bc + 6'h01;
          end else begin
            next_sh = {sh[30:0], 1'b0};
            if (rdf && bc > 6'h08) next_rd = {rd[22:0], s_sd[1]};
            if (bc == 6'h20) next_state = done_s;
          end
        end
      end
      done_s: begin
        next_cs_n  = 1'b1;
        next_state = idle_s;
      end
      default: next_state = idle_s;
    endcase
    // busy and data line drive come from flops, same timing as the state they follow
    next_busy = (next_state != idle_s);
    next_oe   = ~next_cs_n & ~(next_rdf & (next_bc > 6'h08));
    if (sync_rise) begin
      next_prof = profile_i;
      if (upd) begin
        next_upd_cnt = upd_cnt + 2'h1;
        if (upd_cnt == 2'h1) begin
          next_upd     = 1'b0;
          next_upd_cnt = 2'h0;
        end
      end else if (upd_req) begin
        next_upd     = 1'b1;
        next_upd_req = update_i;
      end
    end
  end
  // registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= idle_s; sync_q <= 1'b0; hc <= 4'h0; bc <= 6'h00; sh <= 32'h0;
      rd <= 24'h0; rdf <= 1'b0; sck <= 1'b0; cs_n <= 1'b1;
      upd_req <= 1'b0; upd <= 1'b0; upd_cnt <= 2'h0; prof <= 4'h0;
      busy <= 1'b0; oe <= 1'b0;
    end else begin
      state <= next_state; sync_q <= next_sync_q; hc <= next_hc; bc <= next_bc; sh <= next_sh;
      rd <= next_rd; rdf <= next_rdf; sck <= next_sck; cs_n <= next_cs_n;
      upd_req <= next_upd_req; upd <= next_upd; upd_cnt <= next_upd_cnt; prof <= next_prof;
      busy <= next_busy; oe <= next_oe;
    end
  end
  logic osc, mrst;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc  <= 1'b0;
      mrst <= 1'b0;
    end else begin
      osc  <= osc_sel_i;
      mrst <= master_reset_i;
    end
  end
  // pin drive, data line 0 only while writing
  assign pins.cs_n                = cs_n;
  assign pins.sclk                = sck;
  assign pins.sdio_host           = {3'h0, sh[31]};
  assign pins.sdio_host_oe        = {3'h0, oe};
  assign pins.io_update           = upd;
  assign pins.profile_select_pins = prof;
  assign pins.osc_mode_sel        = osc;
  assign pins.master_reset        = mrst;
  assign busy_o                   = busy;
  assign rdata_o                  = rd;
endmodule
`default_nettype wire

// ---- bench/dds_pins_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module dds_pins_sva (
  // clock, reset and sync enable
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       sync_en_i,
  // link pins
  input  wire logic       sync_clk,
  input  wire logic       io_update,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] sdio,
  input  wire logic [3:0] sdio_dev_oe
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // sync clock: two cycles high, then low
  sequence sync_pulse;
    sync_clk ##1 !sync_clk;
  endsequence
  // a frame of 32 serial clocks at 16 cycles each
  sequence frame_end;
    ##[490:560] $rose(cs_n);
  endsequence
  sync_high_a: assert property (disable iff (!arst_n_i || !sync_en_i) $rose(sync_clk) |=> sync_pulse)
    else $error("sync clock high phase wrong");
  sync_period_a: assert property (disable iff (!arst_n_i || !sync_en_i) $rose(sync_clk) |-> ##4 $rose(sync_clk))
    else $error("sync clock period wrong");
  update_width_a: assert property ($rose(io_update) |-> io_update[*4])
    else $error("update strobe too short");
  frame_len_a: assert property ($fell(cs_n) |-> frame_end)
    else $error("frame length wrong");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("serial clock low phase short");
  data_setup_a: assert property ($rose(sclk) && !cs_n |-> $stable(sdio[0]))
    else $error("data moved at serial clock rise");
  sclk_idle_a: assert property (cs_n[*4] |-> $stable(sclk))
    else $error("serial clock moved while deselected");
  dev_quiet_a: assert property (cs_n[*4] |-> sdio_dev_oe == 4'h0)
    else $error("device drives data while deselected");
endmodule
`default_nettype wire

// ---- bench/tb_dds_host_control_pins.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_dds_host_control_pins;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, sync_en_i = 1'b1, start_i = 1'b0, read_i = 1'b0;
  logic        update_i = 1'b0, osc_sel_i = 1'b0, master_reset_i = 1'b0;
  logic [6:0]  addr_i = 7'h00;
  logic [23:0] data_i = 24'h000000;
  logic [3:0]  profile_i = 4'h0;
  logic [23:0] func_one_o, active_data_o, rdata_o, exp_fn;
  logic [7:0]  active_addr_o;
  logic [3:0]  profile_o;
  logic [2:0]  profile_function_o;
  logic        update_pulse_o, ramp_up_o, ramp_down_o, osc_enable_o, busy_o, sv;
  int          error_cnt = 0, checked = 0;
  // clock source
  always #5 clk_i = ~clk_i;
  dds_pins_if pins ();
  dds_pins_device dds_pins_device_inst (.clk_i, .arst_n_i, .pins(pins.device), .sync_en_i, .func_one_o,
    .active_addr_o, .active_data_o, .update_pulse_o, .profile_o, .profile_function_o, .ramp_up_o,
    .ramp_down_o, .osc_enable_o);
  dds_pins_host dds_pins_host_inst (.clk_i, .arst_n_i, .pins(pins.host), .start_i, .read_i, .addr_i,
    .data_i, .update_i, .profile_i, .osc_sel_i, .master_reset_i, .busy_o, .rdata_o);
  dds_pins_sva dds_pins_sva_inst (.clk_i, .arst_n_i, .sync_en_i, .sync_clk(pins.sync_clk),
    .io_update(pins.io_update), .cs_n(pins.cs_n), .sclk(pins.sclk), .sdio(pins.sdio),
    .sdio_dev_oe(pins.sdio_dev_oe));
  // compare and report
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // step past n clock edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one serial frame, waits until the host is idle again
  task automatic frame(input logic rd, input logic [6:0] a, input logic [23:0] d);
    int i;
    read_i = rd;
    addr_i = a;
    data_i = d;
    start_i = 1'b1;
    cyc(1);
    start_i = 1'b0;
    for (i = 0; i < 800 && busy_o !== 1'b0; i++) cyc(1);
    chk({23'h000000, busy_o}, 24'h000000);
  endtask
  // write frame, then commit with the update strobe
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    int i;
    frame(1'b0, a, d);
    chk(func_one_o, exp_fn);
    update_i = 1'b1;
    cyc(1);
    update_i = 1'b0;
    for (i = 0; i < 40 && update_pulse_o !== 1'b1; i++) cyc(1);
    cyc(1);
    if (a == 7'h01) exp_fn = d;
    chk(active_data_o, d);
    chk({16'h0000, active_addr_o}, {17'h00000, a});
    chk(func_one_o, exp_fn);
    chk({21'h000000, profile_function_o}, {21'h000000, exp_fn[14:12]});
    chk({22'h000000, ramp_up_o, ramp_down_o}, {22'h000000, 1'b0, exp_fn[2:0] == 3'h1});
    frame(1'b1, 7'h01, 24'h000000);
    chk(rdata_o, exp_fn);
  endtask
  // verdict
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(67097));
    cyc(2);
    arst_n_i = 1'b1;
    cyc(1);
    exp_fn = dds_pins_pkg::func_one_reset;
    chk(func_one_o, exp_fn);
    wr(7'h01, 24'h007001);
    wr(7'h01, 24'hffffff);
    wr(7'h02, 24'h5a5a5a);
    wr(7'h01, 24'h000000);
    repeat (6) wr(($urandom % 2) ? 7'h01 : 7'($urandom), 24'($urandom));
    repeat (4) begin
      profile_i = 4'($urandom);
      cyc(16);
      chk({20'h00000, profile_o}, {20'h00000, profile_i});
    end
    for (int b = 0; b < 2; b++) begin
      osc_sel_i = b[0];
      cyc(8);
      chk({23'h000000, osc_enable_o}, {23'h000000, b[0]});
    end
    wr(7'h01, 24'h123456);
    master_reset_i = 1'b1;
    cyc(8);
    master_reset_i = 1'b0;
    cyc(4);
    exp_fn = dds_pins_pkg::func_one_reset;
    chk(func_one_o, exp_fn);
    sync_en_i = 1'b0;
    cyc(8);
    sv = pins.sync_clk;
    cyc(12);
    chk({23'h000000, pins.sync_clk}, {23'h000000, sv});
    sync_en_i = 1'b1;
    cyc(12);
    end_sim();
  end
  // watchdog
  initial begin
    #500000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
